//--- tmpb_pkg.sv
`default_nettype none
package tmpb_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam longint CLK_HZ = 250_000_000;
  localparam longint ACK_LIMIT_S = 2;
  localparam longint ACK_LIMIT_CYC = ACK_LIMIT_S * CLK_HZ;
  // ------------------------------------------------------------
  // packet fields
  // ------------------------------------------------------------
  localparam logic [2:0] TM_VERSION = 3'h0;
  localparam logic TM_TYPE = 1'b0;
  localparam logic DFH_PRESENT = 1'b1;
  localparam logic [2:0] PUS_VERSION = 3'h0;
  localparam logic [1:0] SEG_CONT = 2'h0;
  localparam logic [1:0] SEG_FIRST = 2'h1;
  localparam logic [1:0] SEG_LAST = 2'h2;
  localparam logic [1:0] SEG_ALONE = 2'h3;
  localparam logic [7:0] SVC_VERIFY = 8'h01;
  localparam logic [7:0] SUB_ACC_OK = 8'h01;
  localparam logic [7:0] SUB_ACC_FAIL = 8'h02;
  localparam logic [7:0] SVC_SCIENCE = 8'h15;
  localparam logic [7:0] SPARE8 = 8'h00;
  localparam logic [2:0] HDR_LAST = 3'h7;
  localparam int MAX_DF_OCTETS = 1018;
  localparam int DF_FIXED_OCTETS = 12;
  localparam int NW_W = 9;
  localparam logic [NW_W-1:0] MAX_SRC_WORDS = NW_W'((MAX_DF_OCTETS - DF_FIXED_OCTETS) / 2);
  localparam logic [NW_W-1:0] REP_OK_WORDS = 9'h002;
  localparam logic [NW_W-1:0] REP_FAIL_WORDS = 9'h003;
  localparam logic [15:0] LEN_BASE = 16'(DF_FIXED_OCTETS - 1);
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SEQ_SEL = 8'h08;
  localparam logic [7:0] REG_SEQ_VAL = 8'h0C;
  localparam logic [7:0] REG_PKT_CNT = 8'h10;
  localparam int CTRL_ENABLE = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_REP_PEND = 1;
  localparam int ST_REFUSED = 2;
  localparam logic CTRL_ENABLE_RST = 1'b1;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [7:0] {
    FAIL_BAD_SOURCE_PROCESS_ID = 8'h00, FAIL_BAD_LEN = 8'h01, FAIL_BAD_SUM = 8'h02,
    FAIL_BAD_TYPE = 8'h03, FAIL_BAD_SUB = 8'h04, FAIL_BAD_DATA = 8'h05
  } tmpb_fail_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_HDR = 4'b0010, ST_DATA = 4'b0100, ST_PEC = 4'b1000
  } tmpb_state_t;
  typedef struct packed {
    logic [10:0] source_process_id;
    logic [7:0] service;
    logic [7:0] subtype;
    logic [NW_W-1:0] nwords;
    logic [1:0] seg;
  } tmpb_req_t;
  typedef struct packed {
    logic [15:0] pkt_id;
    logic [15:0] seq_ctl;
    logic reject;
    tmpb_fail_t code;
  } tmpb_tc_t;
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [15:0] word;
  } tmpb_word_t;
endpackage
`default_nettype wire

//--- tmpb_packet_builder.sv
// Contract
// - version field always binary 000
// - packet type bit is zero
// - header-present flag set on every packet
// - primary header field order and widths
// - reserved and test source ids never emitted; only requests are screened, reports echo the command id unchecked
// - segmentation 11 except science data packets
// - science grouping flags first/cont/last/alone
// - group order follows sequence count
// - per-source counter increments per packet; the code keeps one counter per value of the low SRC_BITS bits of the source id
// - length field is data octets minus one
// - data field at most 1018 octets
// - data field whole words, length odd
// - data field header layout with time
// - spare header bits are zero
// - utilisation version field is zero
// - time stamp sampled at fixed point
// - packet ends with error check word
// - report carries command's source id
// - acceptance report within two seconds
// - report data: command id, sequence control
// - rejection report with failure code
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module tmpb_packet_builder #(
  parameter int SRC_BITS = 4,
  parameter logic [15:0] PEC_POLY = 16'h1021,
  parameter logic [15:0] PEC_INIT = 16'hFFFF,
  parameter logic [10:0] EGSE_ID_LO = 11'h7E0,
  parameter logic [10:0] EGSE_ID_HI = 11'h7EF,
  parameter logic [10:0] TIME_ID = 11'h000,
  parameter logic [10:0] IDLE_ID = 11'h7FF,
  parameter longint ACK_LIMIT = tmpb_pkg::ACK_LIMIT_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // packet requests
  input wire logic req_valid,
  input wire tmpb_pkg::tmpb_req_t req,
  output logic req_ready,
  // source data
  input wire logic src_valid,
  input wire logic [15:0] src_word,
  output logic src_ready,
  // command verification events
  input wire logic tc_valid,
  input wire tmpb_pkg::tmpb_tc_t tc,
  output logic tc_ready,
  // on-board time
  input wire logic [47:0] obt_time,
  // telemetry stream
  output var tmpb_pkg::tmpb_word_t tm_out
);
  localparam int NSRC = 2 ** SRC_BITS;
  generate
    if (SRC_BITS < 1 || SRC_BITS > 11) begin : g_bad
      $error("SRC_BITS must be 1 to 11");
    end
    if (ACK_LIMIT < 64) begin : g_bad_ack
      $error("ACK_LIMIT too small");
    end
  endgenerate

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic [15:0] pec_step(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      if (r[15] ^ w[i]) begin
        r = (r << 1) ^ PEC_POLY;
      end else begin
        r = r << 1;
      end
    end
    return r;
  endfunction

  function automatic logic id_refused(input logic [10:0] a);
    return (a >= EGSE_ID_LO && a <= EGSE_ID_HI) || a == TIME_ID || a == IDLE_ID;
  endfunction

  function automatic logic [SRC_BITS-1:0] src_idx(input logic [10:0] a);
    return a[SRC_BITS-1:0];
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  tmpb_pkg::tmpb_state_t state, next_state;
  logic [tmpb_pkg::NW_W-1:0] cnt, next_cnt;
  logic [2:0] widx, next_widx;
  logic [1:0] ridx, next_ridx;
  logic [15:0] hdr [8];
  logic [15:0] next_hdr [8];
  logic [15:0] rep_w [3];
  logic [15:0] next_rep_w [3];
  logic [13:0] seq_cnt [NSRC];
  logic [13:0] next_seq_cnt [NSRC];
  logic is_rep, next_is_rep;
  logic rep_rej, next_rep_rej;
  logic rep_pend, next_rep_pend;
  tmpb_pkg::tmpb_tc_t rep_buf, next_rep_buf;
  logic [15:0] crc, next_crc;
  logic refused, next_refused;
  logic enable, next_enable;
  logic [SRC_BITS-1:0] seq_sel, next_seq_sel;
  logic [15:0] pkt_cnt, next_pkt_cnt;
  tmpb_pkg::tmpb_word_t next_tm;
  logic [31:0] next_rdata;
  logic next_req_ready, next_src_ready, next_tc_ready;
  logic start;
  logic [10:0] s_id;
  logic [7:0] s_svc, s_sub;
  logic [tmpb_pkg::NW_W-1:0] s_n;
  logic [1:0] s_seg;
  logic emit;
  logic [15:0] e_word;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_widx = widx;
    next_ridx = ridx;
    next_hdr = hdr;
    next_rep_w = rep_w;
    next_seq_cnt = seq_cnt;
    next_is_rep = is_rep;
    next_rep_rej = rep_rej;
    next_rep_pend = rep_pend;
    next_rep_buf = rep_buf;
    next_crc = crc;
    next_refused = refused;
    next_enable = enable;
    next_seq_sel = seq_sel;
    next_pkt_cnt = pkt_cnt;
    next_tm = '0;
    next_rdata = 32'h0000_0000;
    start = 1'b0;
    s_id = 11'h000;
    s_svc = 8'h00;
    s_sub = 8'h00;
    s_n = '0;
    s_seg = tmpb_pkg::SEG_ALONE;
    emit = 1'b0;
    e_word = 16'h0000;
    // software side; later hardware sets win over these clears
    if (reg_wr) begin
      case (reg_addr)
        tmpb_pkg::REG_CTRL: next_enable = reg_wdata[tmpb_pkg::CTRL_ENABLE];
        tmpb_pkg::REG_STATUS: if (reg_wdata[tmpb_pkg::ST_REFUSED]) next_refused = 1'b0;
        tmpb_pkg::REG_SEQ_SEL: next_seq_sel = reg_wdata[SRC_BITS-1:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        tmpb_pkg::REG_CTRL: next_rdata = 32'(enable);
        tmpb_pkg::REG_STATUS: next_rdata = 32'({refused, rep_pend, state != tmpb_pkg::ST_IDLE});
        tmpb_pkg::REG_SEQ_SEL: next_rdata = 32'(seq_sel);
        tmpb_pkg::REG_SEQ_VAL: next_rdata = 32'(seq_cnt[seq_sel]);
        tmpb_pkg::REG_PKT_CNT: next_rdata = 32'(pkt_cnt);
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    if (tc_valid && tc_ready) begin
      next_rep_pend = 1'b1;
      next_rep_buf = tc;
    end
    case (state)
      tmpb_pkg::ST_IDLE: begin
        if (rep_pend) begin
          // verification reports go first to meet their deadline
          start = 1'b1;
          s_id = rep_buf.pkt_id[10:0];
          s_svc = tmpb_pkg::SVC_VERIFY;
          s_sub = rep_buf.reject ? tmpb_pkg::SUB_ACC_FAIL : tmpb_pkg::SUB_ACC_OK;
          s_n = rep_buf.reject ? tmpb_pkg::REP_FAIL_WORDS : tmpb_pkg::REP_OK_WORDS;
          next_is_rep = 1'b1;
          next_rep_rej = rep_buf.reject;
          next_rep_pend = 1'b0;
          next_rep_w[0] = rep_buf.pkt_id;
          next_rep_w[1] = rep_buf.seq_ctl;
          next_rep_w[2] = {tmpb_pkg::SPARE8, rep_buf.code};
        end else if (req_valid && req_ready) begin
          // refused requests are swallowed and flagged in status
          if (id_refused(req.source_process_id) || req.nwords > tmpb_pkg::MAX_SRC_WORDS) begin
            next_refused = 1'b1;
          end else begin
            start = 1'b1;
            s_id = req.source_process_id;
            s_svc = req.service;
            s_sub = req.subtype;
            s_n = req.nwords;
            // grouping only honoured for science data
            s_seg = (req.service == tmpb_pkg::SVC_SCIENCE) ? req.seg : tmpb_pkg::SEG_ALONE;
            next_is_rep = 1'b0;
          end
        end
      end
      tmpb_pkg::ST_HDR: begin
        emit = 1'b1;
        e_word = hdr[widx];
        next_tm.sop = (widx == 3'h0);
        next_widx = widx + 3'h1;
        if (widx == tmpb_pkg::HDR_LAST) begin
          next_state = (cnt == '0) ? tmpb_pkg::ST_PEC : tmpb_pkg::ST_DATA;
        end
      end
      tmpb_pkg::ST_DATA: begin
        if (is_rep || (src_valid && src_ready)) begin
          emit = 1'b1;
          e_word = is_rep ? rep_w[ridx] : src_word;
          next_ridx = ridx + 2'h1;
          next_cnt = cnt - 1'b1;
          if (cnt == 9'h001) begin
            next_state = tmpb_pkg::ST_PEC;
          end
        end
      end
      tmpb_pkg::ST_PEC: begin
        emit = 1'b1;
        e_word = crc;
        next_tm.eop = 1'b1;
        next_pkt_cnt = pkt_cnt + 16'h0001;
        next_state = tmpb_pkg::ST_IDLE;
      end
      default: next_state = tmpb_pkg::ST_IDLE;
    endcase
    if (emit) begin
      next_tm.valid = 1'b1;
      next_tm.word = e_word;
      next_crc = pec_step(crc, e_word);
    end
    if (start) begin
      // count wraps naturally at 14 bits
      next_seq_cnt[src_idx(s_id)] = seq_cnt[src_idx(s_id)] + 14'h0001;
      next_hdr[0] = {tmpb_pkg::TM_VERSION, tmpb_pkg::TM_TYPE, tmpb_pkg::DFH_PRESENT, s_id};
      next_hdr[1] = {s_seg, seq_cnt[src_idx(s_id)]};
      next_hdr[2] = tmpb_pkg::LEN_BASE + {6'h00, s_n, 1'b0};
      next_hdr[3] = {1'b0, tmpb_pkg::PUS_VERSION, 4'h0, s_svc};
      next_hdr[4] = {s_sub, tmpb_pkg::SPARE8};
      // time taken at packet start for every service
      next_hdr[5] = obt_time[47:32];
      next_hdr[6] = obt_time[31:16];
      next_hdr[7] = obt_time[15:0];
      next_cnt = s_n;
      next_widx = 3'h0;
      next_ridx = 2'h0;
      next_crc = PEC_INIT;
      next_state = tmpb_pkg::ST_HDR;
    end
    next_req_ready = (next_state == tmpb_pkg::ST_IDLE) && !next_rep_pend && next_enable;
    next_src_ready = (next_state == tmpb_pkg::ST_DATA) && !next_is_rep;
    next_tc_ready = !next_rep_pend;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= tmpb_pkg::ST_IDLE;
      cnt <= '0;
      widx <= 3'h0;
      ridx <= 2'h0;
      for (int i = 0; i < 8; i++) hdr[i] <= 16'h0000;
      for (int i = 0; i < 3; i++) rep_w[i] <= 16'h0000;
      for (int i = 0; i < NSRC; i++) seq_cnt[i] <= 14'h0000;
      is_rep <= 1'b0;
      rep_rej <= 1'b0;
      rep_pend <= 1'b0;
      rep_buf <= '0;
      crc <= 16'h0000;
      refused <= 1'b0;
      enable <= tmpb_pkg::CTRL_ENABLE_RST;
      seq_sel <= '0;
      pkt_cnt <= 16'h0000;
      tm_out <= '0;
      reg_rdata <= 32'h0000_0000;
      req_ready <= 1'b0;
      src_ready <= 1'b0;
      tc_ready <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      widx <= next_widx;
      ridx <= next_ridx;
      hdr <= next_hdr;
      rep_w <= next_rep_w;
      seq_cnt <= next_seq_cnt;
      is_rep <= next_is_rep;
      rep_rej <= next_rep_rej;
      rep_pend <= next_rep_pend;
      rep_buf <= next_rep_buf;
      crc <= next_crc;
      refused <= next_refused;
      enable <= next_enable;
      seq_sel <= next_seq_sel;
      pkt_cnt <= next_pkt_cnt;
      tm_out <= next_tm;
      reg_rdata <= next_rdata;
      req_ready <= next_req_ready;
      src_ready <= next_src_ready;
      tc_ready <= next_tc_ready;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [9:0] pos, pos_cur;
  logic [15:0] mon_crc;
  logic [31:0] ack_wait;
  assign pos_cur = tm_out.sop ? 10'h000 : pos;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 10'h000;
      mon_crc <= 16'h0000;
      ack_wait <= 32'h0000_0000;
    end else begin
      if (tm_out.valid) pos <= pos_cur + 10'h001;
      if (tm_out.valid && !tm_out.eop) mon_crc <= pec_step(tm_out.sop ? PEC_INIT : mon_crc, tm_out.word);
      if (tm_out.valid && tm_out.sop && is_rep) ack_wait <= 32'h0000_0000;
      else if (rep_pend || (tc_valid && tc_ready)) ack_wait <= ack_wait + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire first_w = tm_out.valid && tm_out.sop;

  chk_ver_field: assert property (first_w |-> tm_out.word[15:13] == 3'h0)
    else $error("version field not zero");
  chk_type_bit: assert property (first_w |-> !tm_out.word[12])
    else $error("packet type bit set");
  chk_hdr_flag: assert property (first_w |-> tm_out.word[11] ##1 (tm_out.valid && !tm_out.sop))
    else $error("header flag clear or header broken");
  chk_id_legal: assert property (first_w && !is_rep |-> !id_refused(tm_out.word[10:0]))
    else $error("reserved source id emitted");
  chk_seg_alone: assert property (tm_out.valid && pos_cur == 10'h001 && hdr[3][7:0] != tmpb_pkg::SVC_SCIENCE
    |-> tm_out.word[15:14] == tmpb_pkg::SEG_ALONE)
    else $error("segmentation not stand-alone");
  chk_seq_step: assert property (state == tmpb_pkg::ST_IDLE && next_state == tmpb_pkg::ST_HDR
    |=> seq_cnt[src_idx(hdr[0][10:0])] == hdr[1][13:0] + 14'h0001)
    else $error("sequence count did not step");
  chk_len_odd: assert property (tm_out.valid && pos_cur == 10'h002
    |-> tm_out.word[0] && tm_out.word <= 16'd1017)
    else $error("length field even or too large");
  chk_len_match: assert property (tm_out.valid && tm_out.eop
    |-> 16'(pos_cur) == 16'h0002 + ((hdr[2] + 16'h0001) >> 1))
    else $error("length field disagrees with packet");
  chk_dfh_spare: assert property (tm_out.valid && pos_cur == 10'h003
    |-> tm_out.word[15:8] == 8'h00 ##1 tm_out.word[7:0] == 8'h00)
    else $error("data field header spare or version nonzero");
  chk_pec_word: assert property (tm_out.valid && tm_out.eop |-> tm_out.word == mon_crc)
    else $error("error check word wrong");
  chk_ack_deadline: assert property (ack_wait < 32'(ACK_LIMIT))
    else $error("acceptance report late");
  chk_rep_id: assert property (first_w && is_rep |-> tm_out.word[10:0] == rep_w[0][10:0])
    else $error("report source id differs");
  chk_rep_body: assert property (tm_out.valid && is_rep && pos_cur == 10'h008
    |-> tm_out.word == rep_w[0] ##1 tm_out.word == rep_w[1])
    else $error("report data wrong");
  chk_rep_kind: assert property (tm_out.valid && is_rep && pos_cur == 10'h004
    |-> tm_out.word[15:8] == (rep_rej ? tmpb_pkg::SUB_ACC_FAIL : tmpb_pkg::SUB_ACC_OK))
    else $error("report subtype wrong");

  cov_acc_ok: cover property (tm_out.eop && is_rep && !rep_rej);
  cov_acc_fail: cover property (tm_out.eop && is_rep && rep_rej);
  cov_group_first: cover property (tm_out.valid && pos_cur == 10'h001 && tm_out.word[15:14] == tmpb_pkg::SEG_FIRST);
  cov_max_len: cover property (tm_out.valid && pos_cur == 10'h002 && tm_out.word == 16'd1017);
endmodule // tmpb_packet_builder
`default_nettype wire

//--- tmpb_ground_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmpb_ground_model #(
  parameter logic [15:0] POLY = 16'h1021,
  parameter logic [15:0] INIT = 16'hffff
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // downlink stream
  input wire tmpb_pkg::tmpb_word_t tm
);
  // ------------------------------------------------------------
  // capture of one packet
  // ------------------------------------------------------------
  logic [15:0] pkt [0:1023];
  int len = 0;
  int done_cnt = 0;
  int alarms = 0;
  int grp_err = 0;
  logic crc_ok = 1'b0;
  logic [13:0] grp_next = 14'h0000;

  function automatic logic [15:0] crc_of(input int n);
    logic [15:0] c;
    c = INIT;
    for (int i = 0; i < n; i++) begin
      for (int b = 15; b >= 0; b--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ pkt[i][b]) ? POLY : 16'h0000);
      end
    end
    return c;
  endfunction

  always @(posedge clk_sys) begin
    if (rst_n && tm.valid === 1'b1) begin
      if (tm.sop === 1'b1) begin
        len = 0;
      end
      if (len < 1024) begin
        pkt[len] = tm.word;
      end
      len++;
      if (tm.eop === 1'b1) begin
        crc_ok = (crc_of(len - 1) === pkt[len - 1]);
        // bad version is raised as an alarm; the packet is still counted and its grouping checked
        if (pkt[0][15:13] !== 3'h0) alarms++;
        // grouping is ours to follow; transport treats packets alone
        if (pkt[1][15:14] == 2'h1) begin
          grp_next = pkt[1][13:0] + 14'h0001;
        end else if (pkt[1][15:14] != 2'h3) begin
          if (pkt[1][13:0] !== grp_next) grp_err++;
          grp_next = pkt[1][13:0] + 14'h0001;
        end
        done_cnt++;
      end
    end
  end
endmodule // tmpb_ground_model
`default_nettype wire

//--- tmpb_packet_builder_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module tmpb_packet_builder_test;
  // ------------------------------------------------------------
  // stimulus and wiring
  // ------------------------------------------------------------
  localparam int ACK_LIM = 200;
  localparam logic [1:0] GRP [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
  localparam logic [10:0] BAD [4] = '{11'h7e0, 11'h7ef, 11'h000, 11'h7ff};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic req_valid = 1'b0;
  tmpb_pkg::tmpb_req_t req = '0;
  logic req_ready;
  logic src_valid = 1'b0;
  logic [15:0] src_word = 16'h0000;
  logic src_ready;
  logic tc_valid = 1'b0;
  tmpb_pkg::tmpb_tc_t tc = '0;
  logic tc_ready;
  logic [47:0] obt_time = '0;
  tmpb_pkg::tmpb_word_t tm_out;
  int seed = 97621;
  int num_errors = 0;
  int checks_done = 0;
  int total = 0;
  logic [13:0] seqs [0:15];
  logic [15:0] dat [0:511];
  logic [31:0] rd;

  always #2 clk_sys = ~clk_sys;

  tmpb_packet_builder #(.ACK_LIMIT(ACK_LIM)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .src_valid(src_valid), .src_word(src_word), .src_ready(src_ready),
    .tc_valid(tc_valid), .tc(tc), .tc_ready(tc_ready), .obt_time(obt_time), .tm_out(tm_out));
  tmpb_ground_model gm (.clk_sys(clk_sys), .rst_n(rst_n), .tm(tm_out));

  // ------------------------------------------------------------
  // bus and packet tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // a used-up wait counts as a mismatch and closes the run
  task automatic time_out(input string what);
    num_errors++;
    $display("[ERR] %0t %s wait timed out", $time, what);
    end_sim();
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
  endtask

  // gives up after lim cycles, so a lost packet cannot hang the run
  task automatic wait_pkt(input int c0, input int lim);
    int k;
    k = 0;
    while (gm.done_cnt == c0 && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    if (gm.done_cnt == c0) begin
      num_errors++;
      $display("[ERR] %0t packet wait timed out", $time);
      end_sim();
    end
    @(posedge clk_sys);
  endtask

  task automatic check_pkt(input logic [10:0] id, input logic [7:0] svc, input logic [7:0] sub, input int n,
      input logic [1:0] sg);
    `CHK(gm.len, n + 9)
    `CHK(gm.pkt[0], {3'h0, 1'b0, 1'b1, id})
    `CHK(gm.pkt[1], {sg, seqs[id[3:0]]})
    `CHK(gm.pkt[2], 16'(11 + 2 * n))
    `CHK(gm.pkt[3], {8'h00, svc})
    `CHK(gm.pkt[4], {sub, 8'h00})
    `CHK({gm.pkt[5], gm.pkt[6], gm.pkt[7]}, obt_time)
    for (int i = 0; i < n; i++) `CHK(gm.pkt[8 + i], dat[i])
    `CHK(gm.crc_ok, 1'b1)
    seqs[id[3:0]] = seqs[id[3:0]] + 14'h0001;
    total++;
  endtask

  task automatic send_pkt(input logic [10:0] id, input logic [7:0] svc, input int n, input logic [1:0] sg,
      input logic refuse);
    int c0;
    int k;
    int t;
    logic [7:0] sub;
    c0 = gm.done_cnt;
    sub = 8'($random(seed));
    for (int i = 0; i < n; i++) dat[i] = 16'($random(seed));
    obt_time <= {16'($random(seed)), 32'($random(seed))};
    req_valid <= 1'b1;
    req <= '{source_process_id: id, service: svc, subtype: sub, nwords: 9'(n), seg: sg};
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (req_ready !== 1'b1 && k < 100);
    if (req_ready !== 1'b1) time_out("request");
    req_valid <= 1'b0;
    if (refuse) begin
      reg_read(tmpb_pkg::REG_STATUS, rd);
      `CHK(rd[tmpb_pkg::ST_REFUSED], 1'b1)
      `CHK(gm.done_cnt, c0)
      reg_write(tmpb_pkg::REG_STATUS, 32'h0000_0004);
      reg_read(tmpb_pkg::REG_STATUS, rd);
      `CHK(rd[tmpb_pkg::ST_REFUSED], 1'b0)
    end else begin
      k = 0;
      t = 0;
      src_valid <= (n > 0);
      src_word <= dat[0];
      while (k < n && t < 2000) begin
        @(posedge clk_sys);
        t++;
        if (src_ready === 1'b1) k++;
        src_valid <= (k < n);
        src_word <= dat[k];
      end
      if (k < n) time_out("source data");
      wait_pkt(c0, 600);
      check_pkt(id, svc, sub, n, (svc == 8'h15) ? sg : 2'h3);
    end
  endtask

  task automatic send_tc(input logic rej, input logic [7:0] code);
    int c0;
    int k;
    logic [15:0] pid;
    logic [15:0] sc;
    c0 = gm.done_cnt;
    pid = {5'($random(seed)), 7'h05, 4'($random(seed))};
    sc = 16'($random(seed));
    tc_valid <= 1'b1;
    tc <= '{pkt_id: pid, seq_ctl: sc, reject: rej, code: tmpb_pkg::tmpb_fail_t'(code)};
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (tc_ready !== 1'b1 && k < 100);
    if (tc_ready !== 1'b1) time_out("command");
    tc_valid <= 1'b0;
    dat[0] = pid;
    dat[1] = sc;
    dat[2] = {8'h00, code};
    wait_pkt(c0, ACK_LIM);
    check_pkt(pid[10:0], 8'h01, rej ? 8'h02 : 8'h01, rej ? 3 : 2, 2'h3);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    for (int i = 0; i < 16; i++) seqs[i] = 14'h0000;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reg_read(tmpb_pkg::REG_CTRL, rd);
    `CHK(rd, 32'h0000_0001)
    reg_read(8'h40, rd);
    `CHK(rd, 32'h0000_0000)
    reg_read(tmpb_pkg::REG_STATUS, rd);
    `CHK(rd, 32'h0000_0000)
    for (int i = 0; i < 12; i++) begin
      // random science packets stand alone; grouping is kept to the ordered group below
      send_pkt({7'h01, 4'($random(seed))}, (i % 3 == 0) ? 8'h15 : {1'b1, 7'($random(seed))}, $random(seed) & 7,
        (i % 3 == 0) ? 2'h3 : 2'($random(seed)), 1'b0);
    end
    foreach (GRP[i]) send_pkt(11'h025, 8'h15, i, GRP[i], 1'b0);
    send_pkt(11'h026, 8'h03, 0, 2'h0, 1'b0);
    send_pkt(11'h027, 8'h03, 503, 2'h3, 1'b0);
    send_pkt(11'h027, 8'h03, 504, 2'h3, 1'b1);
    foreach (BAD[i]) send_pkt(BAD[i], 8'h03, 1, 2'h3, 1'b1);
    for (int i = 0; i < 7; i++) send_tc(i < 6, 8'(i % 6));
    reg_write(tmpb_pkg::REG_SEQ_SEL, 32'h0000_0005);
    reg_read(tmpb_pkg::REG_SEQ_SEL, rd);
    `CHK(rd, 32'h0000_0005)
    reg_read(tmpb_pkg::REG_SEQ_VAL, rd);
    `CHK(rd, {18'h0_0000, seqs[5]})
    reg_read(tmpb_pkg::REG_PKT_CNT, rd);
    `CHK(rd, 32'(total))
    reg_write(tmpb_pkg::REG_CTRL, 32'h0000_0000);
    reg_read(tmpb_pkg::REG_CTRL, rd);
    `CHK(rd, 32'h0000_0000)
    `CHK(req_ready, 1'b0)
    reg_write(tmpb_pkg::REG_CTRL, 32'h0000_0001);
    `CHK(gm.alarms, 0)
    `CHK(gm.grp_err, 0)
    end_sim();
  end
endmodule // tmpb_packet_builder_test
`default_nettype wire
